// file: pkg/nvac_pkg.sv
// Package for the processor access path to the data nonvolatile array
package nvac_pkg;

    // I/O space offsets
    localparam logic [5:0] CTRL_OFFSET     = 6'h1c;
    localparam logic [5:0] DATA_OFFSET     = 6'h1d;
    localparam logic [5:0] ADDR_LO_OFFSET  = 6'h1e;
    localparam logic [5:0] ADDR_HI_OFFSET  = 6'h1f;

    // Control register fields
    localparam int READ_STROBE_BIT  = 0;
    localparam int WRITE_STROBE_BIT = 1;
    localparam int WRITE_ARM_BIT    = 2;
    localparam int READY_IRQ_BIT    = 3;

    // Reset values
    localparam logic [7:0]  DATA_RESET = 8'h00;
    localparam logic [10:0] ADDR_RESET = 11'h000;

    // Widths
    localparam int ADDR_WIDTH = 11;
    localparam int DATA_WIDTH = 8;

    // Timing: arm window and stalls in mclk cycles, write duration in oscillator cycles
    localparam logic [2:0]  ARM_CYCLES        = 3'h4;
    localparam logic [2:0]  READ_STALL_CYCLES = 3'h4;
    localparam logic [2:0]  WRITE_STALL_CYCLES = 3'h2;
    localparam int          OSC_FREQ_KHZ      = 1000;
    localparam int          WRITE_TIME_US     = 8448;
    localparam logic [13:0] WRITE_OSC_CYCLES  =
        14'(WRITE_TIME_US * OSC_FREQ_KHZ / 1000);

    // One I/O access from the processor
    typedef struct packed {
        logic [5:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } nvac_io_req_type;

    // Array side signals
    typedef struct packed {
        logic [10:0] addr;
        logic        read;
        logic        prog_start;
        logic [7:0]  wdata;
    } nvac_array_req_type;

endpackage : nvac_pkg

// file: design/nvac_write_timer.sv
// Write duration timer counting edges of the calibrated oscillator
`timescale 1ns/1ps
module nvac_write_timer (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Synchronised oscillator rising edge
    input  wire logic osc_rise,
    // Control
    input  wire logic start,
    output logic      done
);

    logic        running;
    logic [13:0] count;

    // Duration depends only on the oscillator, not on the processor clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            running <= 1'b0;
            count   <= 14'h0000;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !running) begin
                running <= 1'b1;
                count   <= 14'h0000;
            end else if (running && osc_rise) begin
                if (count == nvac_pkg::WRITE_OSC_CYCLES - 14'h0001) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    count <= count + 14'h0001;
                end
            end
        end
    end

endmodule : nvac_write_timer

// file: design/nvac_ctrl.sv
// Processor access controller for the data nonvolatile array
//
// Operation
// - Data register carries write and read bytes
// - Control bits 7..4 read zero, ignore writes
// - Ready interrupt needs enable and global flag
// - Ready interrupt is level while not busy
// - Strobe within four cycles of arm programs
// - Strobe without arm is ignored
// - Arm clears itself after four cycles
// - Write strobe clears when write completes
// - Write launch stalls processor two cycles
// - Read strobe loads data register immediately
// - Read stalls processor four cycles
// - Busy write refuses reads and address changes
// - Duration is 8448 oscillator cycles
// - Address is eleven bits, upper bits zero
`timescale 1ns/1ps
module nvac_ctrl (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // Processor I/O access
    input  wire nvac_pkg::nvac_io_req_type   io_req,
    output logic [7:0]                       io_rdata,
    // Processor status and control
    input  wire logic                        global_irq_enable,
    output logic                             cpu_stall,
    output logic                             ready_irq,
    // Array
    output nvac_pkg::nvac_array_req_type     array_req,
    input  wire logic [7:0]                  array_rdata,
    output logic                             array_busy,
    // Calibrated oscillator
    input  wire logic                        osc_1mhz
);

    logic [10:0] nv_address;
    logic [7:0]  nv_data_byte;
    logic [7:0]  prog_data;
    logic        ready_irq_enable;
    logic        write_arm;
    logic        write_strobe;
    logic [2:0]  arm_count;
    logic [2:0]  stall_count;
    logic        ctrl_wr;
    logic        read_go;
    logic        write_go;
    logic        write_done;
    // Decoded register writes
    logic        data_wr;
    logic        addr_lo_wr;
    logic        addr_hi_wr;
    logic        arm_wr;
    // Oscillator sampling
    logic        osc_meta;
    logic        osc_sync;
    logic        osc_prev;
    logic        osc_rise;

    // Register write decode
    assign ctrl_wr    = io_req.wr && (io_req.addr == nvac_pkg::CTRL_OFFSET);
    assign data_wr    = io_req.wr && (io_req.addr == nvac_pkg::DATA_OFFSET);
    // Address halves are locked while a write is in progress
    assign addr_lo_wr = io_req.wr && (io_req.addr == nvac_pkg::ADDR_LO_OFFSET)
                        && !write_strobe;
    assign addr_hi_wr = io_req.wr && (io_req.addr == nvac_pkg::ADDR_HI_OFFSET)
                        && !write_strobe;
    assign arm_wr     = ctrl_wr && io_req.wdata[nvac_pkg::WRITE_ARM_BIT];
    // Reads are refused while busy: no load and no stall follow
    assign read_go  = ctrl_wr && io_req.wdata[nvac_pkg::READ_STROBE_BIT]
                      && !write_strobe;
    // Arm must already be standing; a write that sets both at once does not launch
    assign write_go = ctrl_wr && io_req.wdata[nvac_pkg::WRITE_STROBE_BIT]
                      && write_arm && !write_strobe;

    // Address register, frozen while a write is in progress
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nv_address <= nvac_pkg::ADDR_RESET;
        end else if (addr_lo_wr) begin
            nv_address[7:0] <= io_req.wdata;
        end else if (addr_hi_wr) begin
            nv_address[10:8] <= io_req.wdata[2:0];
        end
    end

    // Data register: software writes, read results land here
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nv_data_byte <= nvac_pkg::DATA_RESET;
        end else if (read_go) begin
            nv_data_byte <= array_rdata;
        end else if (data_wr) begin
            nv_data_byte <= io_req.wdata;
        end
    end

    // Byte under programming is captured so later data writes cannot disturb it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prog_data <= nvac_pkg::DATA_RESET;
        end else if (write_go) begin
            prog_data <= nv_data_byte;
        end
    end

    // Interrupt enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ready_irq_enable <= 1'b0;
        end else if (ctrl_wr) begin
            ready_irq_enable <= io_req.wdata[nvac_pkg::READY_IRQ_BIT];
        end
    end

    // Arm window countdown; a fresh arm write restarts it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arm_count <= 3'h0;
        end else if (arm_wr) begin
            arm_count <= nvac_pkg::ARM_CYCLES;
        end else if (arm_count != 3'h0) begin
            arm_count <= arm_count - 3'h1;
        end
    end

    // Arm bit drops by itself when the window runs out, so a late strobe is ignored
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            write_arm <= 1'b0;
        end else if (arm_wr) begin
            write_arm <= 1'b1;
        end else if (arm_count == 3'h1) begin
            write_arm <= 1'b0;
        end else if (arm_count == 3'h0 && ctrl_wr) begin
            write_arm <= 1'b0;
        end
    end

    // Write strobe doubles as busy; software cannot clear it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            write_strobe <= 1'b0;
        end else if (write_go) begin
            write_strobe <= 1'b1;
        end else if (write_done) begin
            write_strobe <= 1'b0;
        end
    end

    // Processor stall after each launched access
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stall_count <= 3'h0;
        end else if (read_go) begin
            stall_count <= nvac_pkg::READ_STALL_CYCLES;
        end else if (write_go) begin
            stall_count <= nvac_pkg::WRITE_STALL_CYCLES;
        end else if (stall_count != 3'h0) begin
            stall_count <= stall_count - 3'h1;
        end
    end

    assign cpu_stall = (stall_count != 3'h0);

    // Level request held for as long as no write is pending
    assign ready_irq = ready_irq_enable && global_irq_enable && !write_strobe;

    // Array side
    always_comb begin
        array_req.addr       = nv_address;
        array_req.read       = read_go;
        array_req.prog_start = write_go;
        array_req.wdata      = prog_data;
    end
    assign array_busy = write_strobe;

    // Two-stage synchroniser; only the second stage feeds the edge detector
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= osc_1mhz;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // Counting oscillator edges keeps the write time independent of mclk
    assign osc_rise = osc_sync & ~osc_prev;

    // Write duration timer sees only synchronised oscillator edges
    nvac_write_timer u_write_timer (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .osc_rise (osc_rise),
        .start    (write_go),
        .done     (write_done)
    );

    // Register read mux; strobe for read always reads back zero
    always_comb begin
        io_rdata = 8'h00;
        unique case (io_req.addr)
            nvac_pkg::CTRL_OFFSET:    io_rdata = {4'h0, ready_irq_enable, write_arm,
                                                 write_strobe, 1'b0};
            nvac_pkg::DATA_OFFSET:    io_rdata = nv_data_byte;
            nvac_pkg::ADDR_LO_OFFSET: io_rdata = nv_address[7:0];
            nvac_pkg::ADDR_HI_OFFSET: io_rdata = {5'h00, nv_address[10:8]};
            default:                  io_rdata = 8'h00;
        endcase
    end

endmodule : nvac_ctrl

// file: verification/nvac_ctrl_checker.sv
// Port assertions for the nonvolatile access controller
`timescale 1ns/1ps
module nvac_ctrl_checker (
    // Clock and reset
    input wire logic                         mclk,
    input wire logic                         rst_n,
    // Observed ports
    input wire nvac_pkg::nvac_io_req_type    io_req,
    input wire logic [7:0]                   io_rdata,
    input wire logic                         global_irq_enable,
    input wire logic                         cpu_stall,
    input wire logic                         ready_irq,
    input wire nvac_pkg::nvac_array_req_type array_req,
    input wire logic                         array_busy
);
    localparam logic [5:0] C = nvac_pkg::CTRL_OFFSET;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_RSV: assert property (io_req.addr == C |-> io_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    AST_IRQ: assert property (ready_irq |-> global_irq_enable && !array_busy)
        else $error("ready request while masked or busy");
    AST_RD_STALL: assert property (array_req.read |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall length wrong");
    AST_WR_STALL: assert property (array_req.prog_start |=> cpu_stall [*2] ##1 !cpu_stall)
        else $error("write stall length wrong");
    AST_LAUNCH: assert property (array_req.prog_start |=> array_busy [*8])
        else $error("busy not held after launch");
    AST_PROG: assert property (array_req.prog_start |-> io_req.wr && io_req.addr == C
        && io_req.wdata[1] && !array_busy)
        else $error("launch without strobe write");
    AST_ARM: assert property (io_req.wr && io_req.addr == C && io_req.wdata[2]
        ##1 (!(io_req.wr && io_req.addr == C && io_req.wdata[2])) [*4]
        |-> (io_req.addr != C || io_rdata[2]) ##1 (io_req.addr != C || !io_rdata[2]))
        else $error("arm bit did not clear after its window");
    AST_NORD: assert property (array_busy |-> !array_req.read)
        else $error("read taken while busy");
    AST_ADDR: assert property (array_busy && $past(array_busy) |-> $stable(array_req.addr))
        else $error("address moved while busy");
endmodule : nvac_ctrl_checker

bind nvac_ctrl nvac_ctrl_checker u_chk (.mclk(mclk), .rst_n(rst_n), .io_req(io_req),
    .io_rdata(io_rdata), .global_irq_enable(global_irq_enable), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq), .array_req(array_req), .array_busy(array_busy));

// file: verification/nvac_array_model.sv
// Behavioural array and calibrated oscillator beside the controller
`timescale 1ns/1ps
module nvac_array_model (
    // Clock
    input wire logic                         mclk,
    // Array side
    input wire nvac_pkg::nvac_array_req_type array_req,
    output logic [7:0]                       array_rdata,
    output logic                             osc_1mhz
);
    logic [7:0] mem [2048];
    logic       prog_pend = 1'b0;
    initial begin
        osc_1mhz = 1'b0;
        for (int i = 0; i < 2048; i++) mem[i] = 8'(i * 7) ^ 8'h5a;
    end
    // Sped up to eight mclk per period so a full write fits the run
    always #16 osc_1mhz = ~osc_1mhz;
    assign array_rdata = mem[array_req.addr];
    // The controller captures the byte at launch, so it stands only from the next cycle
    always @(posedge mclk) begin
        prog_pend <= array_req.prog_start;
        if (prog_pend) mem[array_req.addr] <= array_req.wdata;
    end
endmodule : nvac_array_model

// file: verification/nvac_ctrl_bench.sv
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
module nvac_ctrl_bench;
    localparam logic [5:0]  C = nvac_pkg::CTRL_OFFSET, DR = nvac_pkg::DATA_OFFSET;
    localparam logic [5:0]  AL = nvac_pkg::ADDR_LO_OFFSET, AH = nvac_pkg::ADDR_HI_OFFSET;
    localparam logic [11:0] D = 12'h0ff, S = 12'h100, B = 12'h200, I = 12'h400;
    logic                         mclk = 1'b0, rst_n = 1'b0, gie = 1'b0, chk = 1'b0;
    nvac_pkg::nvac_io_req_type    io_req = '0;
    nvac_pkg::nvac_array_req_type array_req;
    logic [7:0]                   io_rdata, array_rdata, d;
    logic                         cpu_stall, ready_irq, array_busy, osc_1mhz;
    logic [10:0]                  a;
    logic [23:0]                  q[$], e;
    logic [31:0]                  rnd = 32'hdae32144;
    logic [11:0]                  got;
    int                           failures = 0, compares = 0;
    assign got = {1'b0, ready_irq, array_busy, cpu_stall, io_rdata};
    always #2 mclk = ~mclk;
    nvac_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
        .global_irq_enable(gie), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
        .array_req(array_req), .array_rdata(array_rdata), .array_busy(array_busy),
        .osc_1mhz(osc_1mhz));
    nvac_array_model u_mem (.mclk(mclk), .array_req(array_req), .array_rdata(array_rdata),
        .osc_1mhz(osc_1mhz));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic wr(logic [5:0] ad, logic [7:0] wd);
        @(posedge mclk);
        io_req <= '{addr: ad, wr: 1'b1, rd: 1'b0, wdata: wd};
        chk    <= 1'b0;
        @(posedge mclk);
        io_req.wr <= 1'b0;
    endtask : wr
    // Expectation covers the cycle after this edge; chk stays up for back-to-back notes
    task automatic note(logic [5:0] ad, logic [11:0] ex, logic [11:0] m);
        @(posedge mclk);
        io_req.addr <= ad;
        chk         <= 1'b1;
        q.push_back({m, ex});
    endtask : note
    always @(posedge mclk) begin
        if (chk) begin
            e = q.pop_front();
            compares++;
            if ((got & e[23:12]) !== (e[11:0] & e[23:12])) begin
                failures++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got & e[23:12], e[11:0]);
            end
        end
    end
    task automatic print_verdict;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    initial begin
        #400000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        note(C, 12'h000, 12'h7ff);
        wr(C, 8'hf8);
        note(C, 12'h008, I | D);
        @(posedge mclk);
        gie <= 1'b1;
        chk <= 1'b0;
        note(C, 12'h408, I | D);
        note(6'h20, 12'h000, D);
        $display("test registers done");
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            a = rnd[10:0];
            wr(AL, a[7:0]);
            wr(AH, {rnd[15:11], a[10:8]});
            wr(C, 8'h09);
            for (int i = 0; i < 4; i++) note(C, {3'h0, i < 3, 8'h08}, S | D);
            note(DR, {4'h4, 8'(a * 7) ^ 8'h5a}, I | D);
            note(AH, {9'h0, a[10:8]}, D);
        end
        $display("test reads done");
        wr(C, 8'h0c);
        repeat (5) @(posedge mclk);
        wr(C, 8'h0a);
        note(C, 12'h408, B | I | D);
        $display("test arm window done");
        rnd = lfsr(rnd);
        d = rnd[7:0];
        // No flash self-programming runs here, so the write may start at once
        wr(DR, d);
        @(posedge mclk);
        gie <= 1'b0;
        wr(C, 8'h0c);
        wr(C, 8'h0e);
        gie <= 1'b1;
        note(C, 12'h200, B | I);
        wr(AL, ~a[7:0]);
        wr(C, 8'h09);
        note(AL, {4'h0, a[7:0]}, D);
        note(DR, {4'h0, d}, D);
        @(posedge mclk) chk <= 1'b0;
        // Launch to here is about 8 cycles; 8448 osc periods are 67584 mclk
        repeat (67500) @(posedge mclk);
        note(C, 12'h200, B);
        @(posedge mclk) chk <= 1'b0;
        for (int n = 0; n < 200 && array_busy !== 1'b0; n++) @(posedge mclk);
        note(C, 12'h408, B | I | D);
        @(posedge mclk);
        gie <= 1'b0;
        chk <= 1'b0;
        note(C, 12'h008, I | D);
        wr(C, 8'h01);
        note(DR, {4'h0, d}, D);
        @(posedge mclk) chk <= 1'b0;
        $display("test write done");
        print_verdict();
    end
endmodule : nvac_ctrl_bench
